// >>> rtl/uart_map.svh
// Register indices, field positions and reset values of the serial port
`ifndef UART_MAP_SVH
`define UART_MAP_SVH

`define IDX_STATUS_CTRL_A   8'hc0
`define IDX_CTRL_B          8'hc1
`define IDX_FRAME_FORMAT_C  8'hc2
`define IDX_BAUD_LOW        8'hc4
`define IDX_BAUD_HIGH       8'hc5
`define IDX_DATA_PORT       8'hc6

`define A_RX_COMPLETE       7
`define A_TX_COMPLETE       6
`define A_TX_EMPTY          5
`define A_FRAME_ERR         4
`define A_OVERRUN           3
`define A_PARITY_ERR        2
`define A_DOUBLE_SPEED      1
`define A_ADDR_FILTER       0

`define B_RXC_IE            7
`define B_TXC_IE            6
`define B_TXE_IE            5
`define B_RX_EN             4
`define B_TX_EN             3
`define B_SIZE_MSB          2
`define B_RX_NINTH          1
`define B_TX_NINTH          0

`define C_PARITY_HI         5
`define C_PARITY_LO         4
`define C_TWO_STOP          3
`define C_SIZE_HI           2
`define C_SIZE_LO           1

`define RST_STATUS_CTRL_A   8'h20
`define RST_CTRL_B          8'h00
`define RST_FRAME_FORMAT_C  8'h06
`define RST_BAUD            12'h000

`define SAMPLES_NORMAL      5'h10
`define SAMPLES_DOUBLE      5'h08

`endif

// >>> rtl/uart_pkg.sv
// Types shared by the serial port design
package uart_pkg;

    typedef struct packed {
        logic [8:0] data;
        logic       frame_err;
        logic       overrun;
        logic       parity_err;
    } rx_entry_s;

    typedef struct packed {
        logic rx_complete;
        logic tx_complete;
        logic tx_empty;
    } irq_req_s;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b001,
        RX_START = 3'b010,
        RX_BITS  = 3'b100
    } rx_state_e;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_e;

endpackage

// >>> rtl/uart_multiproc_regs.sv
// Serial transceiver with address filtering behind an APB register set
//
// Function
// RULE_01 - With address filter on, data frames are dropped, never buffered.
// RULE_02 - Frame-type bit is first stop bit, or ninth bit in 9-bit mode.
// RULE_03 - Data port write fills transmit buffer; read gives oldest received.
// RULE_04 - Unused upper bits ignored on transmit, read back as zero.
// RULE_05 - Data write while transmit buffer is full is ignored.
// RULE_06 - Enabled transmitter loads idle shifter from buffer, then shifts out.
// RULE_07 - Receive buffer is two deep; a data port read advances it only if data was unread at setup.
// RULE_08 - Receive-complete bit 7 high exactly while unread data exists.
// RULE_09 - Transmit-complete bit 6 sets when idle; clears on ack or write-one.
// RULE_10 - Buffer-empty bit 5 reads one when buffer free; status resets 0x20.
// RULE_11 - Frame error bit 4 shows head character's stop bit was zero.
// RULE_12 - Overrun bit 3 sets when FIFO and shifter full and start arrives.
// RULE_13 - Parity error bit 2 shows head character failed enabled check.
// RULE_14 - Software writes zero to error bit positions of status register.
// RULE_15 - Double speed changes samples per bit from 16 to 8.
// RULE_16 - Each request needs its enable, global enable and its flag.
// RULE_17 - Receiver enable owns input pin; clearing flushes buffer and flags.
// RULE_18 - Transmitter disable waits for shifter and buffer to drain.
// RULE_19 - Software writes ninth bit first and reads ninth bit first.
// RULE_20 - Parity field selects off, reserved, even or odd; checked on receive.
// RULE_21 - Stop select gives one or two transmitted stops; receiver ignores it.
// RULE_22 - Size code gives 5..8 bits, 9 for 111; format resets to 0x06.
// RULE_23 - Twelve-bit divisor; writing low byte reloads the prescaler.
// RULE_24 - Start bit kept by majority of samples 8..10, or 4..6 doubled.
// RULE_25 - Dropped frame leaves flags unchanged and takes no FIFO entry.
`timescale 1ns/1ns
`default_nettype none
`include "uart_map.svh"

module uart_multiproc_regs #(
    parameter int DIV_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              global_irq_enable,
    input  wire logic              tx_complete_ack,
    output uart_pkg::irq_req_s     irq_req,
    input  wire logic              serial_in,
    output logic                   serial_out,
    output logic                   serial_out_en,
    output logic                   serial_in_owned
);
    import uart_pkg::*;

    if (DIV_W < 9 || DIV_W > 12)
    begin : g_chk
        $error("DIV_W must be 9 to 12");
    end

    // Register state
    logic [7:0]       ctrl_a_reg;
    logic [7:0]       ctrl_b_reg;
    logic [7:0]       fmt_c_reg;
    logic [DIV_W-1:0] baud_reg;
    logic [DIV_W-1:0] presc_reg;
    logic             txc_reg;
    logic [31:0]      prdata_reg;
    logic             pop_ok_reg;

    // Bus decode
    wire [9:0] word_idx  = paddr[11:2];
    wire       hit_a     = word_idx == {2'h0, `IDX_STATUS_CTRL_A};
    wire       hit_b     = word_idx == {2'h0, `IDX_CTRL_B};
    wire       hit_c     = word_idx == {2'h0, `IDX_FRAME_FORMAT_C};
    wire       hit_bl    = word_idx == {2'h0, `IDX_BAUD_LOW};
    wire       hit_bh    = word_idx == {2'h0, `IDX_BAUD_HIGH};
    wire       hit_d     = word_idx == {2'h0, `IDX_DATA_PORT};
    wire       hit_any   = hit_a | hit_b | hit_c | hit_bl | hit_bh | hit_d;
    wire       setup     = psel & ~penable;
    wire       access    = psel & penable & hit_any;
    wire       wr        = access & pwrite;
    wire       rd_data   = access & ~pwrite & hit_d;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign prdata  = prdata_reg;

    // Frame format decode
    wire [2:0] size_code = {ctrl_b_reg[`B_SIZE_MSB], fmt_c_reg[`C_SIZE_HI:`C_SIZE_LO]};
    wire       nine      = size_code == 3'h7;
    wire [3:0] nbits     = nine ? 4'h9 :
                           size_code[2] ? 4'h8 : {2'b01, size_code[1:0]} + 4'h1;
    wire [8:0] dmask     = 9'h1ff >> (4'h9 - nbits);
    wire       par_en    = fmt_c_reg[`C_PARITY_HI]; // see RULE_20
    wire       par_odd   = fmt_c_reg[`C_PARITY_LO];
    wire       dbl       = ctrl_a_reg[`A_DOUBLE_SPEED];
    wire [4:0] spb       = dbl ? `SAMPLES_DOUBLE : `SAMPLES_NORMAL; // see RULE_15
    wire [4:0] mid       = {1'b0, spb[4:1]};
    wire       filt_on   = ctrl_a_reg[`A_ADDR_FILTER];
    wire       rx_en     = ctrl_b_reg[`B_RX_EN];

    // Sample-rate tick from the divisor
    wire tick = presc_reg == '0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            presc_reg <= '0;
        else if (wr && hit_bl)
            presc_reg <= {baud_reg[DIV_W-1:8], pwdata[7:0]}; // see RULE_23
        else if (tick)
            presc_reg <= baud_reg;
        else
            presc_reg <= presc_reg - 1'b1;
    end

    // Input pin synchroniser, change taken once stages two and three agree
    logic s1_reg, s2_reg, s3_reg, rx_lvl_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_reg     <= 1'b1;
            s2_reg     <= 1'b1;
            s3_reg     <= 1'b1;
            rx_lvl_reg <= 1'b1;
        end
        else
        begin
            s1_reg <= serial_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
                rx_lvl_reg <= s3_reg;
        end
    end

    // Receiver
    rx_state_e  rx_st_reg;
    logic [4:0] smp_reg;
    logic [3:0] bit_idx_reg;
    logic [1:0] vote_reg;
    logic [11:0] rx_sr_reg;
    rx_entry_s  fifo_reg [0:1];
    logic       hd_reg;
    logic [1:0] cnt_reg;
    rx_entry_s  hold_reg;
    logic       hold_v_reg;

    wire       cur      = rx_lvl_reg;
    wire       maj      = (vote_reg[1] & vote_reg[0]) | (vote_reg[1] & cur)
                        | (vote_reg[0] & cur);
    wire       in_win   = smp_reg >= mid && smp_reg <= mid + 5'h2;
    wire       decide   = tick && smp_reg == mid + 5'h2;
    wire       bit_end  = tick && smp_reg == spb;
    wire [3:0] last_idx = nbits + {3'h0, par_en};
    wire       start_ok = rx_st_reg == RX_START && decide && !maj; // see RULE_24
    wire       done     = rx_st_reg == RX_BITS && decide && bit_idx_reg == last_idx;

    // Completed frame, taken from the shifter plus the stop decision
    wire [8:0] rx_data  = rx_sr_reg[8:0] & dmask; // see RULE_04
    wire       rx_par   = rx_sr_reg[nbits];
    wire       ftype    = nine ? rx_sr_reg[8] : maj; // see RULE_02
    wire       bad_par  = par_en & ((^rx_data) ^ rx_par ^ par_odd);
    wire       keep     = done & ~(filt_on & ~ftype); // see RULE_01
    rx_entry_s new_ent;
    assign new_ent = '{data: rx_data, frame_err: ~maj, overrun: 1'b0,
                       parity_err: bad_par}; // see RULE_11 see RULE_13

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_st_reg   <= RX_IDLE;
            smp_reg     <= '0;
            bit_idx_reg <= '0;
            vote_reg    <= '0;
            rx_sr_reg   <= '0;
        end
        else if (!rx_en)
            rx_st_reg <= RX_IDLE; // see RULE_17
        else if (tick)
        begin
            smp_reg <= smp_reg + 5'h1;
            if (in_win)
                vote_reg <= {vote_reg[0], cur};
            unique case (rx_st_reg)
                RX_IDLE:
                begin
                    smp_reg <= 5'h2;
                    if (!cur)
                        rx_st_reg <= RX_START;
                end
                RX_START:
                begin
                    if (decide && maj)
                        rx_st_reg <= RX_IDLE;
                    else if (bit_end)
                    begin
                        rx_st_reg   <= RX_BITS;
                        smp_reg     <= 5'h1;
                        bit_idx_reg <= '0;
                    end
                end
                RX_BITS:
                begin
                    if (decide)
                        rx_sr_reg[bit_idx_reg] <= maj;
                    if (done)
                        rx_st_reg <= RX_IDLE; // see RULE_21
                    else if (bit_end)
                    begin
                        smp_reg     <= 5'h1;
                        bit_idx_reg <= bit_idx_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    // Two-entry receive FIFO plus the waiting shifter slot
    wire       rxc      = cnt_reg != 2'h0;
    wire       pop      = rd_data & pop_ok_reg & rxc; // see RULE_07
    wire       free     = (cnt_reg != 2'h2) | pop;
    wire       tail     = hd_reg ^ cnt_reg[0];
    wire       push_h   = hold_v_reg & free;
    wire       push_n   = keep & ~hold_v_reg & free; // see RULE_25
    wire       to_hold  = keep & ~push_n & (~hold_v_reg | push_h);
    wire       push     = push_h | push_n;
    wire       ovr      = start_ok & (cnt_reg == 2'h2) & hold_v_reg & ~pop;
    rx_entry_s head;
    assign head = fifo_reg[hd_reg];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fifo_reg[0] <= '0;
            fifo_reg[1] <= '0;
            hd_reg      <= 1'b0;
            cnt_reg     <= '0;
            hold_reg    <= '0;
            hold_v_reg  <= 1'b0;
        end
        else if (!rx_en)
        begin
            cnt_reg    <= '0; // see RULE_17
            hold_v_reg <= 1'b0;
        end
        else
        begin
            if (push)
                fifo_reg[tail] <= push_h ? hold_reg : new_ent; // see RULE_03
            if (pop)
                hd_reg <= ~hd_reg;
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
            if (to_hold)
            begin
                hold_reg   <= new_ent;
                hold_v_reg <= 1'b1;
            end
            else if (push_h)
                hold_v_reg <= 1'b0;
            else if (ovr)
                hold_reg.overrun <= 1'b1; // see RULE_12
        end
    end

    // Transmitter
    tx_state_e   tx_st_reg;
    logic [8:0]  tx_buf_reg;
    logic        tx_full_reg;
    logic [12:0] tx_sr_reg;
    logic [3:0]  tx_left_reg;
    logic [4:0]  tx_smp_reg;
    logic        tx_on_reg;

    wire        udre     = ~tx_full_reg; // see RULE_10
    wire        tx_load  = tx_on_reg & tx_full_reg & (tx_st_reg == TX_IDLE);
    wire        tx_bit   = tick && tx_smp_reg == spb - 5'h1;
    wire        tx_last  = tx_st_reg == TX_SHIFT && tx_bit && tx_left_reg == 4'h1;
    wire [8:0]  tx_d     = tx_buf_reg & dmask;
    wire        tx_par   = (^tx_d) ^ par_odd;
    wire [3:0]  tx_len   = 4'h2 + nbits + {3'h0, par_en}
                         + {3'h0, fmt_c_reg[`C_TWO_STOP]}; // see RULE_21
    logic [12:0] frame;
    always_comb
    begin
        frame = 13'h1fff;
        frame[0] = 1'b0;
        frame[9:1] = tx_d | ~dmask;
        if (par_en)
            frame[nbits + 4'h1] = tx_par; // see RULE_20
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_st_reg   <= TX_IDLE;
            tx_buf_reg  <= '0;
            tx_full_reg <= 1'b0;
            tx_sr_reg   <= 13'h1fff;
            tx_left_reg <= '0;
            tx_smp_reg  <= '0;
            tx_on_reg   <= 1'b0;
        end
        else
        begin
            if (ctrl_b_reg[`B_TX_EN])
                tx_on_reg <= 1'b1;
            else if (tx_st_reg == TX_IDLE && !tx_full_reg)
                tx_on_reg <= 1'b0; // see RULE_18
            if (wr && hit_d && udre)
            begin
                tx_buf_reg  <= {ctrl_b_reg[`B_TX_NINTH], pwdata[7:0]} & dmask; // see RULE_05
                tx_full_reg <= 1'b1;
            end
            else if (tx_load)
                tx_full_reg <= 1'b0;
            unique case (tx_st_reg)
                TX_IDLE:
                    if (tx_load)
                    begin
                        tx_st_reg   <= TX_SHIFT; // see RULE_06
                        tx_sr_reg   <= frame;
                        tx_left_reg <= tx_len;
                        tx_smp_reg  <= '0;
                    end
                TX_SHIFT:
                    if (tick)
                    begin
                        tx_smp_reg <= tx_bit ? 5'h0 : tx_smp_reg + 5'h1;
                        if (tx_bit)
                        begin
                            tx_sr_reg   <= {1'b1, tx_sr_reg[12:1]};
                            tx_left_reg <= tx_left_reg - 4'h1;
                            if (tx_last)
                                tx_st_reg <= TX_IDLE;
                        end
                    end
            endcase
        end
    end

    // Transmit complete: setting beats a clear in the same cycle
    wire txc_set = tx_last & ~tx_full_reg;
    wire txc_clr = tx_complete_ack | (wr & hit_a & pwdata[`A_TX_COMPLETE]);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            txc_reg <= 1'b0;
        else if (txc_set)
            txc_reg <= 1'b1; // see RULE_09
        else if (txc_clr)
            txc_reg <= 1'b0;
    end

    assign serial_out      = tx_st_reg == TX_SHIFT ? tx_sr_reg[0] : 1'b1;
    assign serial_out_en   = tx_on_reg; // see RULE_18
    assign serial_in_owned = rx_en; // see RULE_17

    // Status read view
    wire [7:0] stat_a = {rxc, txc_reg, udre, head.frame_err & rxc,
                         head.overrun & rxc, head.parity_err & rxc,
                         ctrl_a_reg[1:0]}; // see RULE_08 see RULE_11 see RULE_13
    wire [7:0] stat_b = {ctrl_b_reg[7:2], head.data[8] & rxc, ctrl_b_reg[0]};
    wire [7:0] rd_mux = hit_a  ? stat_a :
                        hit_b  ? stat_b :
                        hit_c  ? fmt_c_reg :
                        hit_bl ? baud_reg[7:0] :
                        hit_bh ? {{(16-DIV_W){1'b0}}, baud_reg[DIV_W-1:8]} :
                        hit_d  ? (rxc ? head.data[7:0] : 8'h00) : 8'h00;

    assign irq_req.rx_complete = ctrl_b_reg[`B_RXC_IE] & global_irq_enable & rxc; // see RULE_16
    assign irq_req.tx_complete = ctrl_b_reg[`B_TXC_IE] & global_irq_enable & txc_reg; // see RULE_16
    assign irq_req.tx_empty    = ctrl_b_reg[`B_TXE_IE] & global_irq_enable & udre; // see RULE_16

    // Register writes and read capture
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_a_reg <= `RST_STATUS_CTRL_A & 8'h03;
            ctrl_b_reg <= `RST_CTRL_B;
            fmt_c_reg  <= `RST_FRAME_FORMAT_C; // see RULE_22
            baud_reg   <= DIV_W'(`RST_BAUD);
            prdata_reg <= '0;
            pop_ok_reg <= 1'b0;
        end
        else
        begin
            if (setup)
            begin
                prdata_reg <= {24'h0, rd_mux};
                pop_ok_reg <= rxc;
            end
            if (wr && hit_a)
                ctrl_a_reg <= {6'h0, pwdata[1:0]}; // see RULE_14
            if (wr && hit_b)
                ctrl_b_reg <= {pwdata[7:2], 1'b0, pwdata[0]};
            if (wr && hit_c)
                fmt_c_reg <= {2'h0, pwdata[5:1], 1'b0};
            if (wr && hit_bl)
                baud_reg[7:0] <= pwdata[7:0];
            if (wr && hit_bh)
                baud_reg[DIV_W-1:8] <= pwdata[DIV_W-9:0];
        end
    end

endmodule
`default_nettype wire

// >>> test/uart_checker.sv
// Concurrent checks on the serial port's bus and pin behaviour
`timescale 1ns/1ns
`default_nettype none
module uart_checker #(
    parameter int DIV_W = 12
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               global_irq_enable,
    input wire logic               tx_complete_ack,
    input wire uart_pkg::irq_req_s irq_req,
    input wire logic               serial_in,
    input wire logic               serial_out,
    input wire logic               serial_out_en,
    input wire logic               serial_in_owned
);
    import uart_pkg::*;
    logic [7:0] ctrl_b_reg;
    logic       baud_nz_reg;
    wire        acc = psel && penable;
    wire        wr_b = acc && pwrite && paddr == 12'h304;
    wire        wr_baud = acc && pwrite && paddr[11:3] == 9'h062;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of control B and of a nonzero divisor
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_b_reg <= 8'h00;
        else if (wr_b)
            ctrl_b_reg <= pwdata[7:0];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            baud_nz_reg <= 1'b0;
        else if (wr_baud && pwdata[7:0] != 8'h00)
            baud_nz_reg <= 1'b1;
    end
    sequence data_wr;
        acc && pwrite && paddr == 12'h318 && ctrl_b_reg[3] && !baud_nz_reg;
    endsequence
    sequence start_soon;
        ##[1:260] !serial_out;
    endsequence
    AST_TX_START: assert property (data_wr |-> start_soon)
        else $error("no start bit after data write");
    AST_ZERO_WAIT: assert property (acc |-> pready)
        else $error("access phase not answered");
    AST_READ_UPPER: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_IRQ_GLOBAL: assert property (!global_irq_enable |-> irq_req == 3'b000)
        else $error("request without global enable");
    AST_IRQ_ENABLES: assert property ((3'(irq_req) & ~ctrl_b_reg[7:5]) == 3'b000)
        else $error("request without its enable bit");
    AST_RX_OWNED: assert property (serial_in_owned == ctrl_b_reg[4])
        else $error("input pin ownership differs from enable");
    AST_TX_EN_RISE: assert property ($rose(serial_out_en) |-> ctrl_b_reg[3])
        else $error("output taken while disabled");
    AST_TX_EN_FALL: assert property ($fell(serial_out_en) |-> !ctrl_b_reg[3] && serial_out)
        else $error("output released while enabled or mid frame");
    AST_IDLE_HIGH: assert property (!serial_out_en |-> serial_out)
        else $error("serial output low while released");
endmodule
bind uart_multiproc_regs uart_checker #(.DIV_W(DIV_W)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable),
    .tx_complete_ack(tx_complete_ack), .irq_req(irq_req),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .serial_in_owned(serial_in_owned)
);
`default_nettype wire

// >>> test/serial_node.sv
// Remote serial node: sends frames to the port and captures its frames
`timescale 1ns/1ns
`default_nettype none
module serial_node (
    input  wire logic pclk,
    input  wire logic tx_line,
    output logic      rx_line
);
    initial rx_line = 1'b1;
    // Start bit, then n bits LSB first, then idle high
    task automatic send(input logic [11:0] bits, input int n, input int bt);
        rx_line <= 1'b0;
        repeat (bt) @(posedge pclk);
        for (int i = 0; i < n; i++)
        begin
            rx_line <= bits[i];
            repeat (bt) @(posedge pclk);
        end
        rx_line <= 1'b1;
        repeat (bt) @(posedge pclk);
    endtask
    // Waits for a start bit, samples n bits at their middles
    task automatic recv(output logic [11:0] bits, input int n, input int bt);
        bits = 12'h000;
        while (tx_line !== 1'b0)
            @(posedge pclk);
        repeat (bt / 2) @(posedge pclk);
        for (int i = 0; i < n; i++)
        begin
            repeat (bt) @(posedge pclk);
            bits[i] = tx_line;
        end
    endtask
endmodule
`default_nettype wire

// >>> test/uart_multiproc_regs_tb_top.sv
// Self-checking bench for the serial port register block
`timescale 1ns/1ns
`default_nettype none
`include "uart_map.svh"
module uart_multiproc_regs_tb_top;
    import uart_pkg::*;
    localparam int BT = 16;
    logic        pclk, presetn, psel, penable, pwrite, gie, ack;
    logic        pready, pslverr, so, so_en, si, si_own, err;
    logic [11:0] paddr, f1, f2;
    logic [31:0] pwdata, prdata, rd;
    irq_req_s    irq;
    int          fail_count, samples_checked, cycles;
    logic [7:0]  dat [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    logic [7:0]  st [3] = '{8'ha0, 8'ha0, 8'ha8};
    logic [7:0]  pc [2] = '{8'h26, 8'h36};
    logic [7:0]  pa [2] = '{8'ha4, 8'ha0};
    logic [7:0]  bm [2] = '{8'h18, 8'h1c};
    logic [11:0] df [2] = '{12'h077, 12'h277};
    logic [11:0] af [2] = '{12'h142, 12'h342};

    uart_multiproc_regs #(.DIV_W(12)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .global_irq_enable(gie),
        .tx_complete_ack(ack), .irq_req(irq), .serial_in(si),
        .serial_out(so), .serial_out_en(so_en), .serial_in_owned(si_own)
    );
    serial_node node_u (.pclk(pclk), .tx_line(so), .rx_line(si));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== e)
        begin
            $display("unexpected %s: expected %h, seen %h", what, e, got);
            fail_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e,
                       input string what);
        apb(1'b0, idx, 8'h00);
        check(what, {24'h0, e}, rd);
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, gie, ack} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`IDX_STATUS_CTRL_A, 8'h20, "status a");
        rdc(`IDX_CTRL_B, 8'h00, "ctrl b");
        rdc(`IDX_FRAME_FORMAT_C, 8'h06, "format c");
        apb(1'b0, 8'hc3, 8'h00);
        check("slave error", 32'h1, {31'h0, err});
        wr(`IDX_CTRL_B, 8'h20);
        gie <= 1'b1;
        @(posedge pclk);
        check("irq", 32'h1, {29'h0, irq});
        gie <= 1'b0;
        @(posedge pclk);
        check("irq", 32'h0, {29'h0, irq});
        wr(`IDX_CTRL_B, 8'h18);
        fork
        begin
            wr(`IDX_DATA_PORT, 8'ha5);
            wr(`IDX_DATA_PORT, 8'h3c);
            wr(`IDX_DATA_PORT, 8'hff);
        end
        begin
            node_u.recv(f1, 9, BT);
            node_u.recv(f2, 9, BT);
        end
        join
        check("frame one", 32'h1a5, {20'h0, f1});
        check("frame two", 32'h13c, {20'h0, f2});
        repeat (BT) @(posedge pclk);
        rdc(`IDX_STATUS_CTRL_A, 8'h60, "status a");
        wr(`IDX_STATUS_CTRL_A, 8'h40);
        rdc(`IDX_STATUS_CTRL_A, 8'h20, "status a");
        node_u.send(12'h000, 0, 4);
        rdc(`IDX_STATUS_CTRL_A, 8'h20, "status a");
        foreach (dat[i])
            node_u.send({4'h1, dat[i]}, 9, BT);
        for (int i = 0; i < 3; i++)
        begin
            rdc(`IDX_STATUS_CTRL_A, st[i], "status a");
            rdc(`IDX_DATA_PORT, dat[i], "data");
        end
        rdc(`IDX_STATUS_CTRL_A, 8'h20, "status a");
        for (int i = 0; i < 2; i++)
        begin
            wr(`IDX_FRAME_FORMAT_C, pc[i]);
            node_u.send(12'h201, 10, BT);
            rdc(`IDX_STATUS_CTRL_A, pa[i], "status a");
            rdc(`IDX_DATA_PORT, 8'h01, "data");
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(`IDX_FRAME_FORMAT_C, 8'(i * 2));
            node_u.send(12'hfff, i + 6, BT);
            rdc(`IDX_DATA_PORT, 8'((1 << (i + 5)) - 1), "data");
        end
        node_u.send(12'h055, 9, BT);
        rdc(`IDX_STATUS_CTRL_A, 8'hb0, "status a");
        wr(`IDX_CTRL_B, 8'h08);
        rdc(`IDX_STATUS_CTRL_A, 8'h20, "status a");
        check("rx owned", 32'h0, {31'h0, si_own});
        wr(`IDX_STATUS_CTRL_A, 8'h01);
        for (int i = 0; i < 2; i++)
        begin
            wr(`IDX_CTRL_B, bm[i]);
            node_u.send(df[i], i + 9, BT);
            rdc(`IDX_STATUS_CTRL_A, 8'h21, "status a");
            node_u.send(af[i], i + 9, BT);
            rdc(`IDX_STATUS_CTRL_A, 8'ha1, "status a");
            if (i == 1)
                rdc(`IDX_CTRL_B, 8'h1e, "ctrl b");
            rdc(`IDX_DATA_PORT, 8'h42, "data");
        end
        wr(`IDX_STATUS_CTRL_A, 8'h00);
        wr(`IDX_CTRL_B, 8'h18);
        wr(`IDX_DATA_PORT, 8'h81);
        wr(`IDX_CTRL_B, 8'h10);
        check("out owned", 32'h1, {31'h0, so_en});
        repeat (12 * BT) @(posedge pclk);
        check("out owned", 32'h0, {31'h0, so_en});
        wr(`IDX_CTRL_B, 8'h18);
        wr(`IDX_STATUS_CTRL_A, 8'h42);
        wr(`IDX_FRAME_FORMAT_C, 8'h0e);
        fork
            wr(`IDX_DATA_PORT, 8'h5a);
            node_u.recv(f1, 9, BT / 2);
        join
        check("fast frame", 32'h15a, {20'h0, f1});
        repeat (4) @(posedge pclk);
        rdc(`IDX_STATUS_CTRL_A, 8'h22, "status a");
        repeat (BT) @(posedge pclk);
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
        rdc(`IDX_STATUS_CTRL_A, 8'h22, "status a");
        wr(`IDX_BAUD_LOW, 8'h01);
        node_u.send(12'h15a, 9, BT);
        rdc(`IDX_STATUS_CTRL_A, 8'ha2, "status a");
        rdc(`IDX_DATA_PORT, 8'h5a, "data");
        stop_test();
    end
endmodule
`default_nettype wire
